// >>> lco_cell.sv
// Summary of operation
// - A mirror register returns every cell output sampled in the same cycle.
// - Any reset clears the control register; gate inversion keeps its contents.
// - The cell keeps working from its inputs, independent of processor sleep.
// - Cell on with fast oscillator selected keeps that oscillator running in sleep.
// - Control bit 7 enables the cell; when clear the output is zero.
// - Control bit 6 lets the cell result drive its pin.
// - Control bit 5 reads the final cell output; writes are ignored.
// - Control bit 4 lets a rising output edge set the edge flag.
// - Control bit 3 lets a falling output edge set the edge flag.
// - Codes 7..4 select latch, JK, two-input D and set/reset D functions.
// - Codes 3, 2 and 0 select SR latch, four-input AND and AND-OR.
// - Inversion bit 7 inverts the function output to form the cell output.
// - Inversion bits 3..0 invert gates 4..1 before the function stage.
// - Control and output inversion reset to zero; gate inversion never resets.
// - Either enabled edge sets the flag; a set beats a simultaneous clear.
// - Toggling output inversion makes an edge that interrupts like any other.
// - The function stage takes four gate inputs and gives one output.
//
// Our own choices: the register addresses and the APB interface to the registers.
module lco_cell (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Cell inputs from the data gates, other cells and the clock selector
  input wire logic [3:0] gate_in,
  input wire logic [lco_pkg::NUM_CELLS-1:1] peer_result_in,
  input wire logic fast_osc_selected,
  // Cell outputs
  output logic cell_out,
  output logic pin_out,
  output logic pin_drive_en,
  output logic osc_keep_alive,
  output logic irq
);

  lco_pkg::lco_control_type ctrl_r;
  logic result_invert_r;
  logic [3:0] gate_invert_r;
  logic [0:0] status_r;
  logic [0:0] status_nxt;
  logic [0:0] mask_r;
  logic [lco_pkg::NUM_CELLS-1:0] mirror_r;
  logic cell_prev_r;

  logic [3:0] gate_sync;
  logic [lco_pkg::NUM_CELLS-1:1] peer_sync;
  logic [3:0] gate_eff;
  logic func_result;
  logic cell_nxt;
  logic rise_evt;
  logic fall_evt;
  logic edge_evt;

  logic setup_phase;
  logic wr_done;
  logic addr_hit;
  logic [31:0] rd_nxt;
  lco_pkg::lco_control_type ctrl_view;

  // Gate signals and peer outputs come from logic that may run off other
  // clocks or pins, so they cross into pclk before use.
  lco_sync #(
    .W(4)
  ) u_gate_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(gate_in),
    .sync_out(gate_sync)
  );

  lco_sync #(
    .W(lco_pkg::NUM_CELLS - 1)
  ) u_peer_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(peer_result_in),
    .sync_out(peer_sync)
  );

  // Per-gate inversion ahead of the function stage.
  for (genvar g = 0; g < lco_pkg::NUM_GATES; g++) begin : g_gate_inv
    assign gate_eff[g] = gate_sync[g] ^ gate_invert_r[g];
  end

  lco_function u_function (
    .clk(pclk),
    .rst_n(presetn),
    .enable(ctrl_r.cell_on),
    .function_select(ctrl_r.function_select),
    .gate(gate_eff),
    .result(func_result)
  );

  // Final inversion, then the enable forces the output low when off.
  // The path runs from the gate inputs with no dependence on the bus, so the
  // cell keeps producing results whatever software is doing.
  assign cell_nxt = ctrl_r.cell_on & (func_result ^ result_invert_r);

  // Edge detection on the final output; a change of the output inversion
  // bit shows up here as an ordinary output edge.
  assign rise_evt = cell_out & ~cell_prev_r & ctrl_r.rise_irq_enable;
  assign fall_evt = ~cell_out & cell_prev_r & ctrl_r.fall_irq_enable;
  assign edge_evt = rise_evt | fall_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_out <= 1'b0;
      cell_prev_r <= 1'b0;
      pin_out <= 1'b0;
      pin_drive_en <= 1'b0;
    end else begin
      cell_out <= cell_nxt;
      cell_prev_r <= cell_out;
      pin_out <= cell_nxt & ctrl_r.pin_drive_enable;
      pin_drive_en <= ctrl_r.pin_drive_enable;
    end
  end

  // The fast oscillator is asked to stay up only while it actually feeds
  // an enabled cell; otherwise sleep current is not wasted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_keep_alive <= 1'b0;
    end else begin
      osc_keep_alive <= ctrl_r.cell_on & fast_osc_selected;
    end
  end

  // All cell outputs are sampled on the same edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mirror_r <= '0;
    end else begin
      mirror_r <= {peer_sync, cell_nxt};
    end
  end

  // APB: read data and pready are prepared in the setup cycle, so every
  // access completes in its first access cycle with no wait state.
  assign setup_phase = psel & ~penable;
  assign wr_done = psel & penable & pwrite & pready;

  always_comb begin
    ctrl_view = ctrl_r;
    ctrl_view.cell_result_bit = cell_out;
  end

  always_comb begin
    rd_nxt = '0;
    addr_hit = 1'b1;
    case (paddr)
      lco_pkg::OFS_CONTROL: rd_nxt[7:0] = ctrl_view;
      lco_pkg::OFS_INVERSION: begin
        rd_nxt[lco_pkg::INV_RESULT_BIT] = result_invert_r;
        rd_nxt[lco_pkg::INV_GATE_MSB:0] = gate_invert_r;
      end
      lco_pkg::OFS_MIRROR: rd_nxt[lco_pkg::NUM_CELLS-1:0] = mirror_r;
      lco_pkg::OFS_IRQ_STATUS: rd_nxt[lco_pkg::IRQ_EDGE_BIT] = status_r[0];
      lco_pkg::OFS_IRQ_MASK: rd_nxt[lco_pkg::IRQ_EDGE_BIT] = mask_r[0];
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup_phase;
      if (setup_phase) begin
        pslverr <= ~addr_hit;
        prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
      end else begin
        pslverr <= 1'b0;
        prdata <= '0;
      end
    end
  end

  // Control register: cleared by every reset; the result bit is never stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= lco_pkg::CONTROL_RESET;
    end else if (wr_done && paddr == lco_pkg::OFS_CONTROL) begin
      ctrl_r <= pwdata[7:0];
      ctrl_r.cell_result_bit <= 1'b0;
    end
  end

  // Output inversion resets with the control register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_invert_r <= 1'b0;
    end else if (wr_done && paddr == lco_pkg::OFS_INVERSION) begin
      result_invert_r <= pwdata[lco_pkg::INV_RESULT_BIT];
    end
  end

  // Gate inversion has no reset: it is unknown after power-up and keeps
  // its value across later resets, so software must program it.
  always_ff @(posedge pclk) begin
    if (wr_done && paddr == lco_pkg::OFS_INVERSION) begin
      gate_invert_r <= pwdata[lco_pkg::INV_GATE_MSB:0];
    end
  end

  // Sticky edge flag, cleared by writing one; a new edge wins the clear.
  always_comb begin
    status_nxt = status_r;
    if (wr_done && paddr == lco_pkg::OFS_IRQ_STATUS) begin
      status_nxt[0] = status_r[0] & ~pwdata[lco_pkg::IRQ_EDGE_BIT];
    end
    if (edge_evt) begin
      status_nxt[0] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= lco_pkg::IRQ_RESET;
      mask_r <= lco_pkg::IRQ_RESET;
      irq <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (wr_done && paddr == lco_pkg::OFS_IRQ_MASK) begin
        mask_r[0] <= pwdata[lco_pkg::IRQ_EDGE_BIT];
      end
      irq <= status_r[0] & mask_r[0];
    end
  end

endmodule // lco_cell

// >>> lco_cell_asserts.sv
module lco_cell_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Cell
  input wire logic [3:0] gate_in,
  input wire logic fast_osc_selected,
  input wire logic cell_out,
  input wire logic pin_out,
  input wire logic pin_drive_en,
  input wire logic osc_keep_alive,
  input wire logic irq
);
  logic [7:0] ctrl_r;
  logic inv7_r;
  logic mask_r;
  logic wr_done;
  logic inv_flip;
  logic [3:0] ginv_r;

  assign wr_done = psel & penable & pwrite & pready;
  // A flip of the output inversion only guarantees an output edge when the gate inversion stays put.
  assign inv_flip = wr_done && paddr == lco_pkg::OFS_INVERSION && pwdata[7] != inv7_r && pwdata[3:0] == ginv_r;

  // Gate inversion survives resets in the cell, so its shadow has no reset either.
  always_ff @(posedge pclk) begin
    if (wr_done && paddr == lco_pkg::OFS_INVERSION) begin
      ginv_r <= pwdata[3:0];
    end
  end

  // Shadows of the written configuration, so each check knows what software asked for.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 8'h00;
      inv7_r <= 1'b0;
      mask_r <= 1'b0;
    end else if (wr_done) begin
      if (paddr == lco_pkg::OFS_CONTROL) ctrl_r <= pwdata[7:0];
      if (paddr == lco_pkg::OFS_INVERSION) inv7_r <= pwdata[7];
      if (paddr == lco_pkg::OFS_IRQ_MASK) mask_r <= pwdata[0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_reset_quiet: assert property ($rose(presetn) |-> ##1 !cell_out && !irq && !pin_out)
    else $error("outputs not quiet after reset");
  a_off_zero: assert property (!ctrl_r[7] && !$past(ctrl_r[7]) |-> !cell_out && !pin_out)
    else $error("disabled cell drives a one");
  a_pin_gated: assert property (pin_out |-> pin_drive_en)
    else $error("pin driven while drive disabled");
  a_osc_alive: assert property ($stable(ctrl_r[7] && fast_osc_selected) |->
    osc_keep_alive == (ctrl_r[7] && fast_osc_selected))
    else $error("oscillator keep-alive wrong");
  a_rise_irq: assert property (ctrl_r[4] && mask_r && $rose(cell_out) |-> ##[1:3] irq)
    else $error("rising edge gave no interrupt");
  a_fall_irq: assert property (ctrl_r[3] && mask_r && $fell(cell_out) |-> ##[1:3] irq)
    else $error("falling edge gave no interrupt");
  a_mask_quiet: assert property (!mask_r && !$past(mask_r) |-> !irq)
    else $error("masked flag raised interrupt");
  a_invert_edge: assert property (inv_flip && ctrl_r[7] && $past(ctrl_r[7], 4) &&
    gate_in == $past(gate_in, 4) && $stable(gate_in) |-> ##[1:2] $changed(cell_out))
    else $error("output inversion did not toggle output");
endmodule // lco_cell_asserts

bind lco_cell lco_cell_asserts lco_cell_asserts_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .gate_in, .fast_osc_selected, .cell_out, .pin_out, .pin_drive_en, .osc_keep_alive, .irq);

// >>> lco_function.sv
module lco_function (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration
  input wire logic enable,
  input wire logic [2:0] function_select,
  // Gate outputs after gate inversion
  input wire logic [3:0] gate,
  // Function stage output
  output logic result
);

  logic q_r;
  logic q_nxt;
  logic clk_gate_prev_r;
  logic clk_rise;
  logic set_in;
  logic rst_in;

  // Gate 1 acts as the clock of the flip-flop modes; its rising edge is
  // found against the previous sample, so sequential modes see it one
  // cycle late relative to the combinational ones.
  assign clk_rise = gate[lco_pkg::G1] & ~clk_gate_prev_r;
  assign set_in = gate[lco_pkg::G4];
  assign rst_in = gate[lco_pkg::G3];

  always_comb begin
    q_nxt = q_r;
    case (function_select)
      lco_pkg::FN_SR_LATCH: begin
        if (gate[lco_pkg::G3] | gate[lco_pkg::G4]) begin
          q_nxt = 1'b0;
        end else if (gate[lco_pkg::G1] | gate[lco_pkg::G2]) begin
          q_nxt = 1'b1;
        end
      end
      lco_pkg::FN_DFF_SR: begin
        if (rst_in) begin
          q_nxt = 1'b0;
        end else if (set_in) begin
          q_nxt = 1'b1;
        end else if (clk_rise) begin
          q_nxt = gate[lco_pkg::G2];
        end
      end
      lco_pkg::FN_DFF2_R: begin
        if (rst_in) begin
          q_nxt = 1'b0;
        end else if (clk_rise) begin
          q_nxt = gate[lco_pkg::G2] & gate[lco_pkg::G4];
        end
      end
      lco_pkg::FN_JKFF_R: begin
        if (rst_in) begin
          q_nxt = 1'b0;
        end else if (clk_rise) begin
          case ({gate[lco_pkg::G2], gate[lco_pkg::G4]})
            2'h1: q_nxt = 1'b0;
            2'h2: q_nxt = 1'b1;
            2'h3: q_nxt = ~q_r;
            default: q_nxt = q_r;
          endcase
        end
      end
      lco_pkg::FN_TLATCH_SR: begin
        if (rst_in) begin
          q_nxt = 1'b0;
        end else if (set_in) begin
          q_nxt = 1'b1;
        end else if (gate[lco_pkg::G1]) begin
          q_nxt = gate[lco_pkg::G2];
        end
      end
      default: q_nxt = q_r;
    endcase
  end

  // Stored state is cleared while the cell is off so that it restarts clean.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= 1'b0;
      clk_gate_prev_r <= 1'b0;
    end else begin
      clk_gate_prev_r <= gate[lco_pkg::G1];
      q_r <= enable ? q_nxt : 1'b0;
    end
  end

  // Exactly four gate inputs feed one output.
  always_comb begin
    case (function_select)
      lco_pkg::FN_AND_OR: begin
        result = (gate[lco_pkg::G1] & gate[lco_pkg::G2]) | (gate[lco_pkg::G3] & gate[lco_pkg::G4]);
      end
      lco_pkg::FN_OR_XOR: begin
        result = (gate[lco_pkg::G1] | gate[lco_pkg::G2]) ^ (gate[lco_pkg::G3] | gate[lco_pkg::G4]);
      end
      lco_pkg::FN_AND4: begin
        result = &gate;
      end
      default: result = q_r;
    endcase
  end

endmodule // lco_function

// >>> lco_pkg.sv
package lco_pkg;

  // APB register map, byte addresses of aligned 32-bit words.
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_INVERSION = 8'h04;
  localparam logic [7:0] OFS_MIRROR = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic cell_on;
    logic pin_drive_enable;
    logic cell_result_bit;
    logic rise_irq_enable;
    logic fall_irq_enable;
    logic [2:0] function_select;
  } lco_control_type;

  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Inversion register layout.
  localparam int unsigned INV_RESULT_BIT = 7;
  localparam int unsigned INV_GATE_MSB = 3;
  localparam logic [7:0] INV_WRITE_MASK = 8'h8f;

  // Interrupt status and mask layout: one event, the edge flag.
  localparam int unsigned IRQ_EDGE_BIT = 0;
  localparam logic [0:0] IRQ_RESET = 1'h0;

  // Number of cells seen by the output mirror; this cell sits at bit 0.
  localparam int unsigned NUM_CELLS = 2;
  localparam int unsigned OWN_MIRROR_BIT = 0;

  // Function select codes.
  localparam logic [2:0] FN_AND_OR = 3'h0;
  localparam logic [2:0] FN_OR_XOR = 3'h1;
  localparam logic [2:0] FN_AND4 = 3'h2;
  localparam logic [2:0] FN_SR_LATCH = 3'h3;
  localparam logic [2:0] FN_DFF_SR = 3'h4;
  localparam logic [2:0] FN_DFF2_R = 3'h5;
  localparam logic [2:0] FN_JKFF_R = 3'h6;
  localparam logic [2:0] FN_TLATCH_SR = 3'h7;

  // Gate inputs: gate 1 is bit 0, gate 4 is bit 3.
  localparam int unsigned NUM_GATES = 4;
  localparam int unsigned G1 = 0;
  localparam int unsigned G2 = 1;
  localparam int unsigned G3 = 2;
  localparam int unsigned G4 = 3;

  // Bus data width.
  localparam int unsigned DATA_W = 32;

endpackage

// >>> lco_src.sv
module lco_src (
  // Clock
  input wire logic pclk,
  // Levels requested by the test sequence
  input wire logic [4:0] want,
  // Levels seen by the cell
  output logic [3:0] gate_in,
  output logic [1:1] peer_result_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] lvl = 5'h00;

  // Sources are other on-chip logic, so levels move only just after a clock edge.
  always @(posedge pclk) lvl <= want;
  assign gate_in = lvl[3:0];
  assign peer_result_in = lvl[4];
endmodule // lco_src

// >>> lco_sync.sv
module lco_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous inputs
  input wire logic [W-1:0] async_in,
  // Filtered, synchronised outputs
  output logic [W-1:0] sync_out
);

  // A change is taken only when the second and third stages agree, which
  // also rejects single-cycle glitches on the pins.
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        s1_r <= async_in[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
          sync_out[i] <= s3_r;
        end
      end
    end
  end

endmodule // lco_sync

// >>> logic_cell_output_control_tb.sv
module logic_cell_output_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, cell_out, pin_out, pin_drive_en, osc_keep_alive, irq;
  logic [3:0] gate_in;
  logic [1:1] peer_result_in;
  logic fast_osc_selected = 1'b0;
  logic [4:0] want = 5'h00;
  int bad_count = 0;
  int samples_checked = 0;
  logic [31:0] q;
  logic e, x;
  logic [7:0] seq [27] = '{8'h60, 8'h63, 8'h61, 8'h68, 8'h88, 8'h84, 8'h87, 8'h83, 8'h81, 8'h82, 8'h91,
    8'ha8, 8'hb4, 8'hb7, 8'ha5, 8'ha6, 8'hc8, 8'hc4, 8'hc7, 8'hd5, 8'hd6, 8'he8, 8'he7, 8'he2, 8'he0,
    8'he4, 8'hf1};

  lco_cell lco_cell_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .gate_in, .peer_result_in, .fast_osc_selected, .cell_out, .pin_out, .pin_drive_en,
    .osc_keep_alive, .irq);
  lco_src lco_src_inst (.pclk, .want, .gate_in, .peer_result_in);

  always #5 pclk = ~pclk;

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; idles a cycle after it so strobes never change twice in one step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(n < 20, 1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] xp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, xp);
  endtask

  task automatic gs(input logic [3:0] g);
    want <= {want[4], g};
    repeat (8) @(posedge pclk);
  endtask

  function automatic logic fn(input logic [2:0] m, input logic [3:0] g);
    case (m)
      3'h0: return (g[0] & g[1]) | (g[2] & g[3]);
      3'h1: return (g[0] | g[1]) ^ (g[2] | g[3]);
      default: return &g;
    endcase
  endfunction

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    $display("CHECK FAILED at %0t: run hung", $time);
    test_done();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(lco_pkg::OFS_CONTROL, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk({q[0], e}, 2'b01);
    apb(1'b1, lco_pkg::OFS_INVERSION, 32'h0000_00ff);
    rd(lco_pkg::OFS_INVERSION, 32'h0000_008f);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, lco_pkg::OFS_INVERSION, p ? 32'h0000_008a : 32'h0000_0000);
      for (int m = 0; m < 3; m++) begin
        apb(1'b1, lco_pkg::OFS_CONTROL, 32'h0000_00a0 | m);
        for (int v = 0; v < 16; v++) begin
          gs(v[3:0]);
          x = fn(m[2:0], v[3:0] ^ (p ? 4'ha : 4'h0)) ^ p[0];
          chk({cell_out, pin_out, pin_drive_en}, {x, 2'b00});
          rd(lco_pkg::OFS_CONTROL, 32'h0000_0080 | m | (x << 5));
        end
      end
    end
    gs(4'h0);
    apb(1'b1, lco_pkg::OFS_CONTROL, 32'h0000_0000);
    apb(1'b1, lco_pkg::OFS_INVERSION, 32'h0000_0000);
    foreach (seq[i]) begin
      apb(1'b1, lco_pkg::OFS_CONTROL, 32'h0000_00c0 | seq[i][7:5]);
      gs(seq[i][4:1]);
      chk({cell_out, pin_out, pin_drive_en}, {seq[i][0], seq[i][0], 1'b1});
    end
    gs(4'h0);
    apb(1'b1, lco_pkg::OFS_CONTROL, 32'h0000_0092);
    apb(1'b1, lco_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, lco_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    gs(4'hf);
    rd(lco_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    chk(irq, 1);
    apb(1'b1, lco_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    gs(4'h0);
    rd(lco_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    chk(irq, 0);
    apb(1'b1, lco_pkg::OFS_CONTROL, 32'h0000_008a);
    gs(4'hf);
    rd(lco_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    gs(4'h0);
    rd(lco_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    apb(1'b1, lco_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    // The interrupt output follows the mask one edge after the write lands.
    @(posedge pclk);
    chk(irq, 0);
    apb(1'b1, lco_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    apb(1'b1, lco_pkg::OFS_CONTROL, 32'h0000_0092);
    apb(1'b1, lco_pkg::OFS_INVERSION, 32'h0000_0080);
    // Gates are already low; only the peer level moves, so want is written once in this step.
    want <= 5'h10;
    repeat (8) @(posedge pclk);
    rd(lco_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    rd(lco_pkg::OFS_MIRROR, 32'h0000_0003);
    fast_osc_selected <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(osc_keep_alive, 1);
    apb(1'b1, lco_pkg::OFS_CONTROL, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk({osc_keep_alive, cell_out}, 2'b00);
    apb(1'b1, lco_pkg::OFS_CONTROL, 32'h0000_00d2);
    apb(1'b1, lco_pkg::OFS_INVERSION, 32'h0000_0085);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(lco_pkg::OFS_CONTROL, 32'h0000_0000);
    rd(lco_pkg::OFS_INVERSION, 32'h0000_0005);
    test_done();
  end
endmodule // logic_cell_output_control_tb
